// ---- wake_params.svh ----
// Offsets, field masks and reset values of the wake enable gate
// Summary of operation
// (RULE1) Enabled, latched, globally enabled source drives wake bus
// (RULE2) Disabled source latches status, never drives bus
// (RULE3) Group 3 enable: bits 3:0 pins 20-23
// (RULE4) Group 2 enable: bits 7:0 pins 10-17
// (RULE5) Group 1 enable: bit0 reserved, bit1 ring 2
// (RULE6) Enables reset only on standby power-on
// (RULE7) Status bit sets on event regardless of enables
// (RULE8) Write one clears status; zero writes ignored
// (RULE9) Group 1 bits 2-7: ring1,keyboard,mouse,key,fan1,fan2
// (RULE10) Reserved enable bits read zero, never gate
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH

// Register indices; byte address is four times the index
`define WK_IDX_STATUS3 6'h08
`define WK_IDX_STATUS2 6'h09
`define WK_IDX_STATUS1 6'h0A
`define WK_IDX_RSVD_B 6'h0B
`define WK_IDX_ENABLE3 6'h0C
`define WK_IDX_ENABLE2 6'h0D
`define WK_IDX_ENABLE1 6'h0E
`define WK_IDX_RSVD_F 6'h0F
`define WK_IDX_MASK3 6'h18
`define WK_IDX_MASK2 6'h19
`define WK_IDX_MASK1 6'h1A

// Implemented bits of each group, same layout for status, enable, mask
`define WK_VALID3 8'h0F
`define WK_VALID2 8'hFF
`define WK_VALID1 8'hFE
`define WK_VALID_ALL 24'h0FFFFE

// Reset values
`define WK_ENABLE_RESET 8'h00
`define WK_MASK_RESET 8'h00
`define WK_STATUS_RESET 24'h000000

`endif

// ---- wake_pkg.sv ----
// Types shared by the wake enable gate modules
package wake_pkg;

    // AXI response codes used by the slave
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;

    // Write channel sequencing, Gray coded
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } wr_state_t;

    // Register selected by an address index
    typedef enum logic [3:0] {
        SEL_STATUS3,
        SEL_STATUS2,
        SEL_STATUS1,
        SEL_ENABLE3,
        SEL_ENABLE2,
        SEL_ENABLE1,
        SEL_MASK3,
        SEL_MASK2,
        SEL_MASK1,
        SEL_RSVD,
        SEL_NONE
    } reg_sel_t;

endpackage : wake_pkg

// ---- wake_status_if.sv ----
// Carrier between the register slave and the sticky status latch
interface wake_status_if;
    // Raw wake events, group1 in [7:0], group2 [15:8], group3 [23:16]
    logic [23:0] events;
    // One-cycle write-one-to-clear strobes, same layout
    logic [23:0] clear;
    // Latched status, same layout
    logic [23:0] status;

    modport keeper (
        input events,
        input clear,
        output status
    );

    modport user (
        output events,
        output clear,
        input status
    );
endinterface : wake_status_if

// ---- wake_status_latch.sv ----
// Sticky wake status bits with write-one-to-clear
`include "wake_params.svh"

module wake_status_latch #(
    parameter logic [23:0] VALID_MASK = `WK_VALID_ALL
) (
    // Clock and standby reset
    input wire logic aclk,
    input wire logic aresetn,
    // Status carrier
    wake_status_if.keeper st
);
    import wake_pkg::*;

    logic [23:0] status;

    // One flop per implemented bit; reserved bits stay zero
    genvar i;
    generate
        for (i = 0; i < 24; i++) begin : g_bit
            if (VALID_MASK[i]) begin : g_live
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        status[i] <= 1'b0;
                    end else if (st.events[i]) begin
                        // Set wins over a clear in the same cycle
                        status[i] <= 1'b1; // see RULE7
                    end else if (st.clear[i]) begin
                        status[i] <= 1'b0; // see RULE8
                    end
                end
            end else begin : g_rsvd
                assign status[i] = 1'b0;
            end
        end
    endgenerate

    assign st.status = status;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    status_sets_a: assert property ( // see RULE7
        (st.events & VALID_MASK) != 24'h000000
        |=> (status & $past(st.events & VALID_MASK)) == $past(st.events & VALID_MASK))
        else $error("wake status failed to latch an event");

    clear_one_a: assert property ( // see RULE8
        ((st.clear & ~st.events & VALID_MASK) != 24'h000000)
        |=> (status & $past(st.clear & ~st.events & VALID_MASK)) == 24'h000000)
        else $error("write of one did not clear status");

    zero_keeps_a: assert property ( // see RULE8
        1'b1 |=> (status & ~$past(st.clear)) == ($past(status) & ~$past(st.clear)
            | status & $past(st.events) & ~$past(st.clear)))
        else $error("status bit lost without a clear");

endmodule : wake_status_latch

// ---- wake_enable_gate.sv ----
// Wake enable gate: AXI4-Lite registers, wake bus drive and interrupt
`include "wake_params.svh"

module wake_enable_gate #(
    parameter int ADDR_W = 8
) (
    // Clock and standby-supply power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output wake_pkg::axi_resp_t bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output wake_pkg::axi_resp_t rresp,
    // Wake sources, active high
    input wire logic [3:0] gpio_pins_20_23,
    input wire logic [7:0] gpio_pins_10_17,
    input wire logic ring_indicator_2,
    input wire logic ring_indicator_1,
    input wire logic keyboard_wake,
    input wire logic mouse_wake,
    input wire logic specific_key_wake,
    input wire logic fan_speed_1_wake,
    input wire logic fan_speed_2_wake,
    // Global enable from the neighbouring control register
    input wire logic global_wake_enable,
    // Wake bus toward the chipset, and interrupt
    output logic wake_bus_out_n,
    output logic irq
);
    import wake_pkg::*;

    // Map an address index to a register
    function automatic reg_sel_t reg_decode(input logic [5:0] idx);
        reg_sel_t sel;
        sel = SEL_NONE;
        unique case (idx)
            `WK_IDX_STATUS3: sel = SEL_STATUS3;
            `WK_IDX_STATUS2: sel = SEL_STATUS2;
            `WK_IDX_STATUS1: sel = SEL_STATUS1;
            `WK_IDX_ENABLE3: sel = SEL_ENABLE3;
            `WK_IDX_ENABLE2: sel = SEL_ENABLE2;
            `WK_IDX_ENABLE1: sel = SEL_ENABLE1;
            `WK_IDX_MASK3: sel = SEL_MASK3;
            `WK_IDX_MASK2: sel = SEL_MASK2;
            `WK_IDX_MASK1: sel = SEL_MASK1;
            `WK_IDX_RSVD_B, `WK_IDX_RSVD_F: sel = SEL_RSVD;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction : reg_decode

    // Register state
    logic [7:0] enable3;
    logic [7:0] enable2;
    logic [7:0] enable1;
    logic [23:0] int_mask;
    logic [23:0] enable_all;

    // Write channel holding state
    wr_state_t wr_state;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_do;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [7:0] wr_byte;
    logic wr_lane;

    // Status carrier to the latch
    wake_status_if st_bus ();

    assign st_bus.events = {4'h0, gpio_pins_20_23, gpio_pins_10_17,
        fan_speed_2_wake, fan_speed_1_wake, specific_key_wake, mouse_wake,
        keyboard_wake, ring_indicator_1, ring_indicator_2, 1'b0}; // see RULE9

    wake_status_latch #(
        .VALID_MASK(`WK_VALID_ALL)
    ) u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .st(st_bus.keeper)
    );

    assign enable_all = {enable3, enable2, enable1};

    // Both halves of a write are held; it commits the cycle after
    assign wr_do = (wr_state == WR_IDLE) && !awready && !wready;
    assign wr_sel = reg_decode(awaddr_q[7:2]);
    assign rd_sel = reg_decode(araddr[7:2]);
    assign wr_byte = wdata_q[7:0];
    // Only the low lane carries register data
    assign wr_lane = wstrb_q[0];

    // Write-one-to-clear strobes toward the status latch
    always_comb begin
        st_bus.clear = 24'h000000;
        if (wr_do && wr_lane) begin
            unique case (wr_sel)
                SEL_STATUS3: st_bus.clear[23:16] = wr_byte; // see RULE8
                SEL_STATUS2: st_bus.clear[15:8] = wr_byte; // see RULE8
                SEL_STATUS1: st_bus.clear[7:0] = wr_byte; // see RULE8
                default: st_bus.clear = 24'h000000;
            endcase
        end
    end

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awaddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= WR_IDLE;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_do) begin
            wr_state <= WR_RESP;
            bvalid <= 1'b1;
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid && bready) begin
            wr_state <= WR_IDLE;
            bvalid <= 1'b0;
        end
    end

    // Enables: only the standby reset reaches them; reserved bits forced low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable3 <= `WK_ENABLE_RESET; // see RULE6
            enable2 <= `WK_ENABLE_RESET; // see RULE6
            enable1 <= `WK_ENABLE_RESET; // see RULE6
        end else if (wr_do && wr_lane) begin
            if (wr_sel == SEL_ENABLE3) begin
                enable3 <= wr_byte & `WK_VALID3; // see RULE3
            end
            if (wr_sel == SEL_ENABLE2) begin
                enable2 <= wr_byte & `WK_VALID2; // see RULE4
            end
            if (wr_sel == SEL_ENABLE1) begin
                enable1 <= wr_byte & `WK_VALID1; // see RULE5
            end
        end
    end

    // Interrupt mask, same layout as the status groups
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_mask <= {`WK_MASK_RESET, `WK_MASK_RESET, `WK_MASK_RESET};
        end else if (wr_do && wr_lane) begin
            if (wr_sel == SEL_MASK3) begin
                int_mask[23:16] <= wr_byte & `WK_VALID3;
            end
            if (wr_sel == SEL_MASK2) begin
                int_mask[15:8] <= wr_byte & `WK_VALID2;
            end
            if (wr_sel == SEL_MASK1) begin
                int_mask[7:0] <= wr_byte & `WK_VALID1;
            end
        end
    end

    // Read channel; answer follows the address by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (rd_sel)
                SEL_STATUS3: rdata <= {24'h000000, st_bus.status[23:16]};
                SEL_STATUS2: rdata <= {24'h000000, st_bus.status[15:8]};
                SEL_STATUS1: rdata <= {24'h000000, st_bus.status[7:0]};
                SEL_ENABLE3: rdata <= {24'h000000, enable3}; // see RULE10
                SEL_ENABLE2: rdata <= {24'h000000, enable2};
                SEL_ENABLE1: rdata <= {24'h000000, enable1}; // see RULE10
                SEL_MASK3: rdata <= {24'h000000, int_mask[23:16]};
                SEL_MASK2: rdata <= {24'h000000, int_mask[15:8]};
                SEL_MASK1: rdata <= {24'h000000, int_mask[7:0]};
                default: rdata <= 32'h00000000;
            endcase
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // Wake bus: any enabled latched source while globally enabled.
    // Registered so the pin never glitches on status/enable skew.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_bus_out_n <= 1'b1;
        end else begin
            wake_bus_out_n <= !(global_wake_enable
                && ((st_bus.status & enable_all & `WK_VALID_ALL) != 24'h000000)); // see RULE1 RULE2
        end
    end

    // Level interrupt while an unmasked status bit stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (st_bus.status & int_mask) != 24'h000000;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wake_drive_a: assert property ( // see RULE1
        global_wake_enable && ((st_bus.status & enable_all) != 24'h000000)
        |=> !wake_bus_out_n)
        else $error("enabled latched source did not drive wake bus");

    disabled_quiet_a: assert property ( // see RULE2
        ((st_bus.status & enable_all) == 24'h000000) || !global_wake_enable
        |=> wake_bus_out_n)
        else $error("wake bus driven without an enabled source");

    group3_write_a: assert property ( // see RULE3
        wr_do && wr_lane && wr_sel == SEL_ENABLE3
        |=> enable3 == ($past(wr_byte) & 8'h0F))
        else $error("group 3 enable write wrong");

    group2_write_a: assert property ( // see RULE4
        wr_do && wr_lane && wr_sel == SEL_ENABLE2
        |=> enable2 == $past(wr_byte))
        else $error("group 2 enable write wrong");

    group1_write_a: assert property ( // see RULE5
        wr_do && wr_lane && wr_sel == SEL_ENABLE1
        |=> enable1 == ($past(wr_byte) & 8'hFE))
        else $error("group 1 enable write wrong");

    ring1_gate_a: assert property ( // see RULE9
        global_wake_enable && enable1[2] && st_bus.status[2]
        |=> !wake_bus_out_n)
        else $error("ring indicator 1 enable not at bit 2");

    enable_hold_a: assert property ( // see RULE6
        !(wr_do && wr_lane) |=> $stable(enable_all))
        else $error("enable changed without a write");

    // Own disable: the default one would hide the very cycle under test
    enable_reset_a: assert property (@(posedge aclk) disable iff (1'b0) // see RULE6
        !aresetn |=> enable_all == 24'h000000)
        else $error("enables not cleared by standby reset");

    reserved_zero_a: assert property ( // see RULE10
        (enable_all & ~`WK_VALID_ALL) == 24'h000000)
        else $error("reserved enable bit set");

    read_latency_a: assert property (
        arvalid && arready |=> rvalid ##0 rdata[31:8] == 24'h000000)
        else $error("read answer late or upper bits nonzero");

    irq_level_a: assert property (
        (st_bus.status & int_mask) != 24'h000000 |=> irq)
        else $error("interrupt missing for unmasked status");

    irq_quiet_a: assert property (
        (st_bus.status & int_mask) == 24'h000000 |=> !irq)
        else $error("interrupt raised with no unmasked status");

    // A zero byte must never reach the clear strobes
    zero_write_a: assert property ( // see RULE8
        wr_do && wr_lane && wr_sel == SEL_STATUS1 && wr_byte == 8'h00
        |-> st_bus.clear == 24'h000000)
        else $error("zero write produced a clear strobe");

    reserved_read_a: assert property ( // see RULE10
        arvalid && arready && rd_sel == SEL_RSVD
        |=> rvalid && rdata == 32'h00000000 && rresp == RESP_OKAY)
        else $error("reserved register read not zero");

    reserved_write_a: assert property ( // see RULE10
        wr_do && wr_sel == SEL_RSVD
        |=> $stable(enable_all) && $stable(int_mask))
        else $error("reserved register write changed state");

    // Unmapped writes are refused with an error answer
    slverr_write_a: assert property (
        wr_do && wr_sel == SEL_NONE |=> bvalid && bresp == RESP_SLVERR)
        else $error("unmapped write not answered with error");

    lane_off_a: assert property (
        wr_do && !wr_lane |=> $stable(enable_all) && $stable(int_mask))
        else $error("write without low lane changed state");

    irq_raised_c: cover property (
        $rose(irq));

    wake_asserted_c: cover property (
        $fell(wake_bus_out_n));

    clear_write_c: cover property (
        wr_do && wr_lane && wr_sel == SEL_STATUS1 && wr_byte != 8'h00);

    disabled_event_c: cover property (
        st_bus.status != 24'h000000 && enable_all == 24'h000000);

    slverr_read_c: cover property (
        rvalid && rresp == RESP_SLVERR);

endmodule : wake_enable_gate

// ---- wake_chipset_model.sv ----
// Behavioural chipset side of the wake bus: counts wake requests
module wake_chipset_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Active-low wake bus from the device
    input wire logic wake_bus_out_n,
    // Number of wake requests seen
    output logic [7:0] wake_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_n;

    // A falling bus level marks one new request; a held level counts once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_n <= 1'b1;
            wake_count <= 8'h00;
        end else begin
            last_n <= wake_bus_out_n;
            if (last_n && !wake_bus_out_n) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule : wake_chipset_model

// ---- test_wake_enable_gate.sv ----
// Self-checking bench of the wake enable gate
`include "wake_params.svh"
module test_wake_enable_gate;
    timeunit 1ns;
    timeprecision 1ps;
    import wake_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, global_wake_enable;
    logic awready, wready, bvalid, arready, rvalid, wake_bus_out_n, irq;
    logic [7:0] awaddr, araddr, wake_count, gpio_pins_10_17, r, b;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, gpio_pins_20_23;
    logic ring_indicator_2, ring_indicator_1, keyboard_wake, mouse_wake;
    logic specific_key_wake, fan_speed_1_wake, fan_speed_2_wake;
    axi_resp_t bresp, rresp;
    logic [23:0] ev;
    logic [23:0] vm = `WK_VALID_ALL;
    logic [33:0] rd_q[$];
    axi_resp_t b_q[$];
    int num_errors, checks, cycles, n;

    // Wake sources share one event vector in the status layout
    assign {fan_speed_2_wake, fan_speed_1_wake, specific_key_wake, mouse_wake,
            keyboard_wake, ring_indicator_1, ring_indicator_2} = ev[7:1];
    assign gpio_pins_10_17 = ev[15:8];
    assign gpio_pins_20_23 = ev[19:16];

    wake_enable_gate wake_enable_gate_i (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .gpio_pins_20_23(gpio_pins_20_23), .gpio_pins_10_17(gpio_pins_10_17),
        .ring_indicator_2(ring_indicator_2), .ring_indicator_1(ring_indicator_1),
        .keyboard_wake(keyboard_wake), .mouse_wake(mouse_wake),
        .specific_key_wake(specific_key_wake), .fan_speed_1_wake(fan_speed_1_wake),
        .fan_speed_2_wake(fan_speed_2_wake), .global_wake_enable(global_wake_enable),
        .wake_bus_out_n(wake_bus_out_n), .irq(irq));

    wake_chipset_model wake_chipset_model_i (.aclk(aclk), .aresetn(aresetn),
        .wake_bus_out_n(wake_bus_out_n), .wake_count(wake_count));

    // Free-running 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk_bus(input string name, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk_bus

    task automatic chk_pin(input string name, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask : chk_pin

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // Watcher: each answer on the bus takes the oldest note
    always @(posedge aclk) begin
        if (aresetn && rvalid === 1'b1 && rready) begin
            chk_bus("read data", rd_q.pop_front(), {rresp, rdata});
        end
        if (aresetn && bvalid === 1'b1 && bready) begin
            chk_bus("write resp", {32'h0, b_q.pop_front()}, {32'h0, bresp});
        end
    end

    // Hang guard, well above the six hundred or so cycles the run needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, input axi_resp_t er);
        b_q.push_back(er);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
    endtask : axi_write

    task automatic axi_read(input logic [5:0] idx, input logic [7:0] d, input axi_resp_t er);
        rd_q.push_back({er, 24'h000000, d});
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
    endtask : axi_read

    // One-cycle event, then the two edges until the bus can answer
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
        @(posedge aclk);
    endtask : pulse

    // Outputs looked at mid-cycle, where they are settled
    task automatic look(input logic ew, input logic ei);
        @(negedge aclk);
        chk_pin("wake_bus_out_n", ew, wake_bus_out_n);
        chk_pin("irq", ei, irq);
        @(posedge aclk);
    endtask : look

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    initial begin
        {aresetn, awvalid, wvalid, arvalid, global_wake_enable} = 5'h00;
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        {awaddr, araddr, wdata, ev} = 72'h0;
        void'($urandom(84));
        do_reset();
        // Power-on values of the enables
        for (int g = 0; g < 3; g++) begin
            axi_read(6'(`WK_IDX_ENABLE1 - g), 8'h00, RESP_OKAY);
        end
        // Readback keeps only the implemented enable bits
        for (int k = 0; k < 4; k++) begin
            for (int g = 0; g < 3; g++) begin
                r = (k == 0) ? 8'hFF : 8'($urandom);
                axi_write(6'(`WK_IDX_ENABLE1 - g), r, RESP_OKAY);
                axi_read(6'(`WK_IDX_ENABLE1 - g), r & vm[8*g+:8], RESP_OKAY);
                axi_write(6'(`WK_IDX_ENABLE1 - g), 8'h00, RESP_OKAY);
            end
        end
        // Reserved and unmapped places
        axi_write(`WK_IDX_RSVD_F, 8'hFF, RESP_OKAY);
        axi_read(`WK_IDX_RSVD_F, 8'h00, RESP_OKAY);
        axi_read(`WK_IDX_RSVD_B, 8'h00, RESP_OKAY);
        axi_write(6'h3F, 8'hFF, RESP_SLVERR);
        axi_read(6'h3F, 8'h00, RESP_SLVERR);
        // Low lane off: the write is answered but leaves the enable alone
        wstrb <= 4'hE;
        axi_write(`WK_IDX_ENABLE2, 8'hFF, RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(`WK_IDX_ENABLE2, 8'h00, RESP_OKAY);
        // Every source: latch while disabled, then gate, mask and clear
        global_wake_enable <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            if (vm[i]) begin
                b = 8'h01 << (i % 8);
                pulse(i);
                look(1'b1, 1'b0);
                axi_read(6'(`WK_IDX_STATUS1 - i / 8), b, RESP_OKAY);
                axi_write(6'(`WK_IDX_STATUS1 - i / 8), 8'h00, RESP_OKAY);
                axi_read(6'(`WK_IDX_STATUS1 - i / 8), b, RESP_OKAY);
                axi_write(6'(`WK_IDX_ENABLE1 - i / 8), b, RESP_OKAY);
                n++;
                look(1'b0, 1'b0);
                axi_write(6'(`WK_IDX_MASK1 - i / 8), b, RESP_OKAY);
                look(1'b0, 1'b1);
                global_wake_enable <= 1'b0;
                @(posedge aclk);
                look(1'b1, 1'b1);
                axi_write(6'(`WK_IDX_STATUS1 - i / 8), b, RESP_OKAY);
                global_wake_enable <= 1'b1;
                look(1'b1, 1'b0);
            end
        end
        chk_bus("wake count", 34'(n), {26'h0, wake_count});
        // Group 2 enable written, then the standby reset clears it
        axi_write(`WK_IDX_ENABLE2, 8'hA5, RESP_OKAY);
        do_reset();
        axi_read(`WK_IDX_ENABLE2, 8'h00, RESP_OKAY);
        repeat (3) @(posedge aclk);
        end_sim();
    end
endmodule : test_wake_enable_gate
